// >>> hdl/nsl_persist.sv
/*
 Bus-off persistence timer for one channel: counts blink ticks while bus-off holds.
 Assumes tick_i is a one-cycle pulse from the blink timebase on the same clock.
*/
`timescale 1ns/100ps
module nsl_persist #(
   parameter int TICKS = nsl_pkg::PERSIST_TICKS
) (
   // clock and reset
   input  wire logic CLK_I,
   input  wire logic RESET_I,
   // timebase and condition
   input  wire logic tick_i,
   input  wire logic bus_off_i,
   // persistence reached
   output logic      persist_o
);
   localparam int CW = $clog2(TICKS + 1);

   // tick count and result
   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          hit;
   } nsl_pers_st_t;

   nsl_pers_st_t st_reg;   // present state
   nsl_pers_st_t st_next;  // next state

   // count only while bus-off holds; any clear restarts the wait
   always_comb begin
      st_next = st_reg;
      if (!bus_off_i) begin
         st_next = '0;
      end else if (tick_i && !st_reg.hit) begin
         // the first tick may come at once, so one tick beyond TICKS keeps the minimum
         if (st_reg.cnt == CW'(TICKS)) begin
            st_next.hit = 1'b1;
         end else begin
            st_next.cnt = st_reg.cnt + 1'b1;
         end
      end
   end

   // state register
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign persist_o = st_reg.hit;

   default clocking @(posedge CLK_I); endclocking
   default disable iff (RESET_I);

   // a cleared bus-off drops persistence at once
   property p_clear;
      !bus_off_i |=> !persist_o && (st_reg.cnt == '0);
   endproperty
   a_clear: assert property (p_clear) else $error("persistence kept after clear");
endmodule // nsl_persist

// >>> hdl/nsl_tick.sv
/*
 Blink timebase prescaler: one-cycle pulse every PERIOD clocks.
 Assumes a free-running clock and a synchronous reset.
*/
`timescale 1ns/100ps
module nsl_tick #(
   parameter int PERIOD = nsl_pkg::BLINK_CYCLES
) (
   // clock and reset
   input  wire logic CLK_I,
   input  wire logic RESET_I,
   // timebase
   output logic      tick_o
);
   localparam int CW = (PERIOD > 1) ? $clog2(PERIOD) : 1;

   // counter and pulse
   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          tick;
   } nsl_tick_st_t;

   nsl_tick_st_t st_reg;   // present state
   nsl_tick_st_t st_next;  // next state

   // count to the end of the period, then pulse and wrap
   always_comb begin
      st_next      = st_reg;
      st_next.tick = 1'b0;
      if (st_reg.cnt == CW'(PERIOD - 1)) begin
         st_next.cnt  = '0;
         st_next.tick = 1'b1;
      end else begin
         st_next.cnt = st_reg.cnt + 1'b1;
      end
   end

   // state register
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign tick_o = st_reg.tick;

   default clocking @(posedge CLK_I); endclocking
   default disable iff (RESET_I);

   // ticks never come back to back while the period exceeds one
   property p_tick_gap;
      (PERIOD > 1) && tick_o |=> !tick_o;
   endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("tick pulses too close");
endmodule // nsl_tick

// >>> hdl/nsl_top.sv
/*
 Network status lamp driver: one module lamp and one network lamp per channel,
 driven from protocol engine state flags, with control and status over AXI4-Lite.
 Assumes engine flags come from logic on CLK_I; lamps are two-colour, active high.
*/
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/100ps
module nsl_top #(
   parameter int BLINK_CYCLES  = nsl_pkg::BLINK_CYCLES,
   parameter int PERSIST_TICKS = nsl_pkg::PERSIST_TICKS
) (
   // clock and reset
   input  wire logic                                       CLK_I,
   input  wire logic                                       RESET_I,
   // axi4-lite write address and data
   input  wire logic [7:0]                                 S_AXI_AWADDR_I,
   input  wire logic                                       S_AXI_AWVALID_I,
   output logic                                            S_AXI_AWREADY_O,
   input  wire logic [31:0]                                S_AXI_WDATA_I,
   input  wire logic [3:0]                                 S_AXI_WSTRB_I,
   input  wire logic                                       S_AXI_WVALID_I,
   output logic                                            S_AXI_WREADY_O,
   // axi4-lite write response
   output logic [1:0]                                      S_AXI_BRESP_O,
   output logic                                            S_AXI_BVALID_O,
   input  wire logic                                       S_AXI_BREADY_I,
   // axi4-lite read
   input  wire logic [7:0]                                 S_AXI_ARADDR_I,
   input  wire logic                                       S_AXI_ARVALID_I,
   output logic                                            S_AXI_ARREADY_O,
   output logic [31:0]                                     S_AXI_RDATA_O,
   output logic [1:0]                                      S_AXI_RRESP_O,
   output logic                                            S_AXI_RVALID_O,
   input  wire logic                                       S_AXI_RREADY_I,
   // protocol engine state
   input  wire nsl_pkg::nsl_ch_flags_t [nsl_pkg::NUM_CH-1:0] CH_FLAGS_I,
   input  wire logic                                       MAJOR_FAIL_I,
   // lamps
   output nsl_pkg::nsl_lamp_t                              MODULE_HEALTH_LAMP_O,
   output nsl_pkg::nsl_lamp_t [nsl_pkg::NUM_CH-1:0]        CHANNEL_NETWORK_LAMP_O
);
   localparam int NCH = nsl_pkg::NUM_CH;

   // whole block state: bus slave, control, blink phase, lamp drive
   typedef struct packed {
      logic                           aw_held;   // write address latched
      logic [7:0]                     aw_addr;
      logic                           w_held;    // write data latched
      logic [31:0]                    w_data;
      logic [3:0]                     w_strb;
      logic                           aw_rdy;
      logic                           w_rdy;
      logic                           bvalid;
      logic [1:0]                     bresp;
      logic                           ar_rdy;
      logic                           rvalid;
      logic [31:0]                    rdata;
      logic [1:0]                     rresp;
      logic                           en;        // lamps enabled by software
      logic                           blink;     // blink phase, high = lit
      nsl_pkg::nsl_mode_t [NCH-1:0]   mode;      // decoded network modes
      nsl_pkg::nsl_lamp_t             mod_lamp;
      nsl_pkg::nsl_lamp_t [NCH-1:0]   net_lamp;
   } nsl_top_st_t;

   nsl_top_st_t        st_reg;    // present state
   nsl_top_st_t        st_next;   // next state
   logic               tick_w;    // half-second pulse
   logic [NCH-1:0]     persist_w; // bus-off held ten seconds
   logic [31:0]        rd_w;      // read mux result
   logic               rd_ok_w;   // read address mapped

   // decode one channel's flags into a mode, highest precedence first
   function automatic nsl_pkg::nsl_mode_t chan_mode(input nsl_pkg::nsl_ch_flags_t f,
                                                    input logic major,
                                                    input logic persist);
      nsl_pkg::nsl_mode_t m;
      if (major) begin
         m = nsl_pkg::MODE_OFF;
      end else if (persist) begin
         m = nsl_pkg::MODE_RED;
      end else if (f.dup_found) begin
         m = nsl_pkg::MODE_RED;
      end else if (f.bus_off || f.timeout) begin
         m = nsl_pkg::MODE_RED_BLINK;
      end else if (f.cfg_rx || f.obj_build) begin
         m = nsl_pkg::MODE_GRN_BLINK;
      end else if (f.init || f.dup_check) begin
         m = nsl_pkg::MODE_OFF;
      end else begin
         m = nsl_pkg::MODE_GRN;
      end
      return m;
   endfunction

   // turn a mode and the blink phase into lamp drive
   function automatic nsl_pkg::nsl_lamp_t lamp_of(input nsl_pkg::nsl_mode_t m,
                                                  input logic ph);
      nsl_pkg::nsl_lamp_t l;
      l = nsl_pkg::LAMP_OFF;
      unique case (m)
         nsl_pkg::MODE_OFF:       l = nsl_pkg::LAMP_OFF;
         nsl_pkg::MODE_GRN:       l = nsl_pkg::LAMP_GRN;
         nsl_pkg::MODE_GRN_BLINK: l.grn = ph;
         nsl_pkg::MODE_RED_BLINK: l.red = ph;
         nsl_pkg::MODE_RED:       l = nsl_pkg::LAMP_RED;
      endcase
      return l;
   endfunction

   // half-second timebase shared by blinking and persistence
   nsl_tick #(
      .PERIOD (BLINK_CYCLES)
   ) u_tick (
      .CLK_I   (CLK_I),
      .RESET_I (RESET_I),
      .tick_o  (tick_w)
   );

   // one persistence timer per channel, so channels never interact
   for (genvar i = 0; i < NCH; i++) begin : g_pers
      nsl_persist #(
         .TICKS (PERSIST_TICKS)
      ) u_pers (
         .CLK_I     (CLK_I),
         .RESET_I   (RESET_I),
         .tick_i    (tick_w),
         .bus_off_i (CH_FLAGS_I[i].bus_off),
         .persist_o (persist_w[i])
      );
   end

   // read mux; status shows the block's own live state
   always_comb begin
      rd_w    = '0;
      rd_ok_w = 1'b1;
      unique case (S_AXI_ARADDR_I)
         nsl_pkg::CTRL_OFS: begin
            rd_w[nsl_pkg::CTRL_EN_BIT] = st_reg.en;
         end
         nsl_pkg::STATUS_OFS: begin
            rd_w[nsl_pkg::STS_MODE0_LSB +: nsl_pkg::MODE_W] = st_reg.mode[0];
            rd_w[nsl_pkg::STS_MODE1_LSB +: nsl_pkg::MODE_W] = st_reg.mode[1];
            rd_w[nsl_pkg::STS_PERSIST_LSB +: NCH]           = persist_w;
            rd_w[nsl_pkg::STS_BLINK_BIT]                    = st_reg.blink;
            rd_w[nsl_pkg::STS_MOD_LSB +: 2]                 = st_reg.mod_lamp;
            rd_w[nsl_pkg::STS_EN_BIT]                       = st_reg.en;
         end
         nsl_pkg::FLAGS_OFS: begin
            rd_w[nsl_pkg::FLG_CH0_LSB +: nsl_pkg::FLAGS_W] = CH_FLAGS_I[0];
            rd_w[nsl_pkg::FLG_CH1_LSB +: nsl_pkg::FLAGS_W] = CH_FLAGS_I[1];
            rd_w[nsl_pkg::FLG_MAJOR_BIT]                   = MAJOR_FAIL_I;
         end
         default: begin
            rd_ok_w = 1'b0;  // unmapped reads answer zero with an error
         end
      endcase
   end

   // next state: bus handshakes, control write, blink phase and lamps
   always_comb begin
      st_next = st_reg;
      // address and data are taken independently, in either order
      if (S_AXI_AWVALID_I && st_reg.aw_rdy) begin
         st_next.aw_held = 1'b1;
         st_next.aw_addr = S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && st_reg.w_rdy) begin
         st_next.w_held = 1'b1;
         st_next.w_data = S_AXI_WDATA_I;
         st_next.w_strb = S_AXI_WSTRB_I;
      end
      // response retires first, so a new write cannot overtake it
      if (st_reg.bvalid && S_AXI_BREADY_I) begin
         st_next.bvalid = 1'b0;
      end
      // both halves held: commit and answer
      if (st_reg.aw_held && st_reg.w_held && !st_reg.bvalid) begin
         st_next.aw_held = 1'b0;
         st_next.w_held  = 1'b0;
         st_next.bvalid  = 1'b1;
         if (st_reg.aw_addr == nsl_pkg::CTRL_OFS) begin
            st_next.bresp = nsl_pkg::RESP_OKAY;
            if (st_reg.w_strb[0]) begin
               st_next.en = st_reg.w_data[nsl_pkg::CTRL_EN_BIT];
            end
         end else begin
            st_next.bresp = nsl_pkg::RESP_SLVERR;  // read-only or unmapped
         end
      end
      // ready only while a slot is free; outputs stay registered
      st_next.aw_rdy = !st_next.aw_held && !st_next.bvalid;
      st_next.w_rdy  = !st_next.w_held && !st_next.bvalid;
      // read channel
      if (st_reg.rvalid && S_AXI_RREADY_I) begin
         st_next.rvalid = 1'b0;
      end
      if (S_AXI_ARVALID_I && st_reg.ar_rdy) begin
         st_next.rvalid = 1'b1;
         st_next.rdata  = rd_w;
         st_next.rresp  = rd_ok_w ? nsl_pkg::RESP_OKAY : nsl_pkg::RESP_SLVERR;
      end
      st_next.ar_rdy = !st_next.rvalid;
      // blink phase flips on every half-second pulse
      if (tick_w) begin
         st_next.blink = !st_reg.blink;
      end
      // each channel decoded alone from its own flags
      for (int i = 0; i < NCH; i++) begin
         st_next.mode[i] = chan_mode(CH_FLAGS_I[i], MAJOR_FAIL_I, persist_w[i]);
         st_next.net_lamp[i] = st_reg.en ? lamp_of(st_next.mode[i], st_reg.blink)
                                         : nsl_pkg::LAMP_OFF;
      end
      // module lamp is red only for major failure or both channels stuck
      if (!st_reg.en) begin
         st_next.mod_lamp = nsl_pkg::LAMP_OFF;
      end else if (MAJOR_FAIL_I || (&persist_w)) begin
         st_next.mod_lamp = nsl_pkg::LAMP_RED;
      end else begin
         st_next.mod_lamp = nsl_pkg::LAMP_GRN;
      end
   end

   // state register; reset leaves every lamp dark
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         st_reg      <= '0;
         st_reg.en   <= nsl_pkg::CTRL_RESET[nsl_pkg::CTRL_EN_BIT];
         st_reg.mode <= '{default: nsl_pkg::MODE_OFF};
      end else begin
         st_reg <= st_next;
      end
   end

   // outputs straight from the state register
   assign S_AXI_AWREADY_O        = st_reg.aw_rdy;
   assign S_AXI_WREADY_O         = st_reg.w_rdy;
   assign S_AXI_BRESP_O          = st_reg.bresp;
   assign S_AXI_BVALID_O         = st_reg.bvalid;
   assign S_AXI_ARREADY_O        = st_reg.ar_rdy;
   assign S_AXI_RDATA_O          = st_reg.rdata;
   assign S_AXI_RRESP_O          = st_reg.rresp;
   assign S_AXI_RVALID_O         = st_reg.rvalid;
   assign MODULE_HEALTH_LAMP_O   = st_reg.mod_lamp;
   assign CHANNEL_NETWORK_LAMP_O = st_reg.net_lamp;

   default clocking @(posedge CLK_I); endclocking
   default disable iff (RESET_I);

   // shorthand for channel 0 conditions below major failure
   logic c0_ok;
   assign c0_ok = st_reg.en && !MAJOR_FAIL_I && !persist_w[0];

   property p_dark;
      !st_reg.en |=> MODULE_HEALTH_LAMP_O == nsl_pkg::LAMP_OFF
                     && CHANNEL_NETWORK_LAMP_O == '0;
   endproperty
   a_dark: assert property (p_dark) else $error("lamp lit while disabled");

   property p_major;
      st_reg.en && MAJOR_FAIL_I |=> MODULE_HEALTH_LAMP_O == nsl_pkg::LAMP_RED
                                    && CHANNEL_NETWORK_LAMP_O == '0;
   endproperty
   a_major: assert property (p_major) else $error("major failure lamps wrong");

   property p_persist0;
      st_reg.en && !MAJOR_FAIL_I && persist_w[0] && !persist_w[1]
      |=> CHANNEL_NETWORK_LAMP_O[0] == nsl_pkg::LAMP_RED
          && MODULE_HEALTH_LAMP_O == nsl_pkg::LAMP_GRN;
   endproperty
   a_persist0: assert property (p_persist0) else $error("single persist wrong");

   property p_persist_both;
      st_reg.en && !MAJOR_FAIL_I && (&persist_w)
      |=> MODULE_HEALTH_LAMP_O == nsl_pkg::LAMP_RED
          && CHANNEL_NETWORK_LAMP_O[0] == nsl_pkg::LAMP_RED
          && CHANNEL_NETWORK_LAMP_O[1] == nsl_pkg::LAMP_RED;
   endproperty
   a_persist_both: assert property (p_persist_both) else $error("dual persist wrong");

   property p_dup;
      c0_ok && CH_FLAGS_I[0].dup_found |=> CHANNEL_NETWORK_LAMP_O[0] == nsl_pkg::LAMP_RED;
   endproperty
   a_dup: assert property (p_dup) else $error("duplicate address lamp wrong");

   property p_red_blink;
      c0_ok && !CH_FLAGS_I[0].dup_found && (CH_FLAGS_I[0].bus_off || CH_FLAGS_I[0].timeout)
      |=> !CHANNEL_NETWORK_LAMP_O[0].grn
          && CHANNEL_NETWORK_LAMP_O[0].red == $past(st_reg.blink);
   endproperty
   a_red_blink: assert property (p_red_blink) else $error("red blink wrong");

   property p_grn_blink;
      c0_ok && CH_FLAGS_I[0][6:4] == '0 && (CH_FLAGS_I[0].cfg_rx || CH_FLAGS_I[0].obj_build)
      |=> !CHANNEL_NETWORK_LAMP_O[0].red
          && CHANNEL_NETWORK_LAMP_O[0].grn == $past(st_reg.blink);
   endproperty
   a_grn_blink: assert property (p_grn_blink) else $error("green blink wrong");

   property p_init;
      c0_ok && CH_FLAGS_I[0][6:2] == '0 && (CH_FLAGS_I[0].init || CH_FLAGS_I[0].dup_check)
      |=> CHANNEL_NETWORK_LAMP_O[0] == nsl_pkg::LAMP_OFF
          && MODULE_HEALTH_LAMP_O == nsl_pkg::LAMP_GRN;
   endproperty
   a_init: assert property (p_init) else $error("init lamps wrong");

   property p_normal1;
      st_reg.en && !MAJOR_FAIL_I && !persist_w[0] && !persist_w[1] && CH_FLAGS_I[1] == '0
      |=> CHANNEL_NETWORK_LAMP_O[1] == nsl_pkg::LAMP_GRN
          && MODULE_HEALTH_LAMP_O == nsl_pkg::LAMP_GRN;
   endproperty
   a_normal1: assert property (p_normal1) else $error("normal lamps wrong");

   property p_blink_toggle;
      1'b1 |=> (st_reg.blink ^ $past(st_reg.blink)) == $past(tick_w);
   endproperty
   a_blink_toggle: assert property (p_blink_toggle) else $error("blink phase wrong");

   property p_read_lat;
      S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O;
   endproperty
   a_read_lat: assert property (p_read_lat) else $error("read answer late");

   c_blink:   cover property (CHANNEL_NETWORK_LAMP_O[0].red ##1 !CHANNEL_NETWORK_LAMP_O[0].red);
   c_both:    cover property (MODULE_HEALTH_LAMP_O == nsl_pkg::LAMP_RED && (&persist_w));
   c_write:   cover property (S_AXI_BVALID_O && S_AXI_BREADY_I);
   c_ch_diff: cover property (CHANNEL_NETWORK_LAMP_O[0] != CHANNEL_NETWORK_LAMP_O[1]);
endmodule // nsl_top

// >>> pkg/nsl_pkg.sv
/*
 Shared constants and types for the network status lamp driver: timing, register map,
 lamp encodings, channel state flags and lamp modes.
 Assumes a single 250 MHz clock and an AXI4-Lite register bus with 32-bit data.
*/
package nsl_pkg;
   // clock rate and lamp timing
   localparam int CLK_MHZ           = 250;      // module clock, MHz
   localparam int BLINK_HALF_MS     = 500;      // blink toggle interval, ms
   localparam int BLINK_CYCLES      = BLINK_HALF_MS * CLK_MHZ * 1000;
   localparam int BUSOFF_PERSIST_MS = 10000;    // bus-off persistence time, ms
   localparam int PERSIST_TICKS     = BUSOFF_PERSIST_MS / BLINK_HALF_MS;
   localparam int NUM_CH            = 2;        // fieldbus channels

   // register byte offsets
   localparam logic [7:0] CTRL_OFS   = 8'h00;   // control, read/write
   localparam logic [7:0] STATUS_OFS = 8'h04;   // lamp state, read only
   localparam logic [7:0] FLAGS_OFS  = 8'h08;   // raw engine flags, read only

   // control fields and reset value
   localparam int          CTRL_EN_BIT = 0;     // lamps enabled
   localparam logic [31:0] CTRL_RESET  = 32'h0000_0001;

   // status fields
   localparam int MODE_W          = 5;
   localparam int STS_MODE0_LSB   = 0;
   localparam int STS_MODE1_LSB   = 5;
   localparam int STS_PERSIST_LSB = 10;
   localparam int STS_BLINK_BIT   = 12;
   localparam int STS_MOD_LSB     = 13;
   localparam int STS_EN_BIT      = 15;

   // flag register fields
   localparam int FLAGS_W       = 7;
   localparam int FLG_CH0_LSB   = 0;
   localparam int FLG_CH1_LSB   = 7;
   localparam int FLG_MAJOR_BIT = 14;

   // bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // one two-colour lamp
   typedef struct packed {
      logic red;
      logic grn;
   } nsl_lamp_t;

   localparam nsl_lamp_t LAMP_OFF = '{red: 1'b0, grn: 1'b0};
   localparam nsl_lamp_t LAMP_GRN = '{red: 1'b0, grn: 1'b1};
   localparam nsl_lamp_t LAMP_RED = '{red: 1'b1, grn: 1'b0};

   // per-channel state flags from the protocol engine
   typedef struct packed {
      logic dup_found;   // node address already on the network
      logic bus_off;     // bus-off active
      logic timeout;     // connection timeout
      logic obj_build;   // objects being constructed
      logic cfg_rx;      // configuration being received
      logic dup_check;   // duplicate address check running
      logic init;        // object initialisation running
   } nsl_ch_flags_t;

   // network lamp modes
   typedef enum logic [4:0] {
      MODE_OFF       = 5'h01,
      MODE_GRN       = 5'h02,
      MODE_GRN_BLINK = 5'h04,
      MODE_RED_BLINK = 5'h08,
      MODE_RED       = 5'h10
   } nsl_mode_t;
endpackage

// >>> tb/nsl_lamp_model.sv
/* two-colour lamp model: counts the colour changes seen on one lamp.
 assumes the lamp is sampled on the module clock. */
`timescale 1ns/100ps
module nsl_lamp_model (
   input  wire logic               CLK_I,
   input  wire logic               clr_i,
   input  wire nsl_pkg::nsl_lamp_t lamp_i,
   output int                      toggles_o
);
   nsl_pkg::nsl_lamp_t last;  // colour seen at the previous edge
   // one change per blink phase; clr restarts the count
   always @(posedge CLK_I) begin
      if (clr_i) toggles_o <= 0;
      else if (lamp_i !== last) toggles_o <= toggles_o + 1;
      last <= lamp_i;
   end
endmodule // nsl_lamp_model

// >>> tb/tb_nsl_top.sv
/* bench for nsl_top: lamp modes read back through the status register.
 assumes short blink and persistence counts so the run stays brief. */
`timescale 1ns/100ps
`define CHK(s,e,a) begin tests_run++; if ((a) !== (e)) begin n_errors++; \
   $display("unexpected %s exp %0h got %0h", s, e, a); end end
module tb_nsl_top;
   logic clk = 0, rst = 1, awv = 0, wv = 0, arv = 0, mj = 0, clr = 0;
   logic br = 1, rr = 1;  // responses always accepted at once
   logic [3:0] strb = 4'hf;  // write strobes
   logic [7:0] awa = 0, ara = 0;
   logic [31:0] wd = 0, rdat, rdata;
   logic awrdy, wrdy, bvalid, arrdy, rvalid;
   logic [1:0] bresp, rresp;
   nsl_pkg::nsl_ch_flags_t [1:0] fl = '0;
   nsl_pkg::nsl_lamp_t modl;
   nsl_pkg::nsl_lamp_t [1:0] chl;
   int n, tests_run = 0, n_errors = 0, tog;
   always #2 clk = ~clk;
   nsl_top #(.BLINK_CYCLES(8), .PERSIST_TICKS(3)) DUT (
      .CLK_I(clk), .RESET_I(rst), .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv),
      .S_AXI_AWREADY_O(awrdy), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(strb),
      .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrdy), .S_AXI_BRESP_O(bresp),
      .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(br), .S_AXI_ARADDR_I(ara),
      .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arrdy), .S_AXI_RDATA_O(rdata),
      .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rr),
      .CH_FLAGS_I(fl), .MAJOR_FAIL_I(mj), .MODULE_HEALTH_LAMP_O(modl),
      .CHANNEL_NETWORK_LAMP_O(chl));
   nsl_lamp_model u_lamp (.CLK_I(clk), .clr_i(clr), .lamp_i(chl[0]), .toggles_o(tog));
   task end_of_test;
      $display("checks %0d errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // one clock with a bound on how long any handshake may take
   task tick;
      @(posedge clk);
      n++;
      if (n > 400) begin
         n_errors++;
         end_of_test();
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      n = 0;
      awa <= a;
      wd <= d;
      awv <= 1;
      wv <= 1;
      do begin
         tick();
         if (awv && awrdy) awv <= 0;
         if (wv && wrdy) wv <= 0;
      end while (!bvalid);
      `CHK("bresp", r, bresp)
   endtask
   task rd(input logic [7:0] a, input logic [1:0] r);
      n = 0;
      ara <= a;
      arv <= 1;
      do begin
         tick();
         if (arv && arrdy) arv <= 0;
      end while (!rvalid);
      rdat = rdata;
      `CHK("rresp", r, rresp)
   endtask
   // v = {major, ch1 flags, ch0 flags, module lamp, ch1 mode, ch0 mode}
   task st(input logic [26:0] v, input int w);
      fl <= v[25:12];
      mj <= v[26];
      repeat (w) @(posedge clk);
      rd(8'h04, 2'h0);
      `CHK("status", v[11:0], {rdat[14:13], rdat[9:0]})
      `CHK("module lamp", v[11:10], modl)
      // steady modes show {red, grn} as bits 4 and 1 of the one-hot mode
      for (int c = 0; c < 2; c++) begin
         if (v[c*5 +: 5] != 5'h04 && v[c*5 +: 5] != 5'h08) begin
            `CHK("steady lamp", {v[c*5+4], v[c*5+1]}, chl[c])
         end
      end
   endtask
   logic [26:0] tv [9] = '{
      {1'b0, 7'h00, 7'h01, 2'h1, 5'h02, 5'h01}, {1'b0, 7'h00, 7'h02, 2'h1, 5'h02, 5'h01},
      {1'b0, 7'h04, 7'h00, 2'h1, 5'h04, 5'h02}, {1'b0, 7'h00, 7'h08, 2'h1, 5'h02, 5'h04},
      {1'b0, 7'h10, 7'h00, 2'h1, 5'h08, 5'h02}, {1'b0, 7'h00, 7'h00, 2'h1, 5'h02, 5'h02},
      {1'b0, 7'h20, 7'h40, 2'h1, 5'h08, 5'h10}, {1'b0, 7'h7f, 7'h01, 2'h1, 5'h10, 5'h01},
      {1'b1, 7'h7f, 7'h7f, 2'h2, 5'h01, 5'h01}};
   // register map: reset value, refused write, masked strobe, unmapped read
   task t_bus;
      rd(8'h00, 2'h0);
      `CHK("ctrl reset", 32'h1, rdat)
      wr(8'h04, 32'h0, 2'h2);
      strb <= 4'h0;
      wr(8'h00, 32'h0, 2'h0);
      strb <= 4'hf;
      rd(8'h00, 2'h0);
      `CHK("ctrl kept", 32'h1, rdat)
      rd(8'h40, 2'h2);
      `CHK("unmapped", 32'h0, rdat)
   endtask
   // every channel state in turn, then the raw flags read back
   task t_modes;
      foreach (tv[i]) st(tv[i], 2);
      rd(8'h08, 2'h0);
      `CHK("flags", 32'h7fff, rdat)
   endtask
   // bus-off held on one channel, then both, then cleared and restarted
   task t_persist;
      st({1'b0, 7'h00, 7'h20, 2'h1, 5'h02, 5'h10}, 40);
      st({1'b0, 7'h20, 7'h20, 2'h2, 5'h10, 5'h10}, 40);
      st({1'b0, 7'h00, 7'h00, 2'h1, 5'h02, 5'h02}, 2);
      st({1'b0, 7'h00, 7'h20, 2'h1, 5'h02, 5'h08}, 2);
   endtask
   // colour changes on a timed-out channel while the other stays green
   task t_blink;
      fl <= {7'h00, 7'h10};
      repeat (4) @(posedge clk);
      clr <= 1;
      @(posedge clk);
      clr <= 0;
      repeat (32) @(posedge clk);
      #1;
      `CHK("blink changes", 4, tog)
      `CHK("ch1 lamp", 2'h1, chl[1])
   endtask
   // software disable darkens the lamps; a reset in mid-run enables them again
   task t_disable;
      wr(8'h00, 32'h0, 2'h0);
      repeat (2) @(posedge clk);
      `CHK("lamps disabled", 6'h00, {modl, chl})
      rst <= 1;
      repeat (2) @(posedge clk);
      rst <= 0;
      rd(8'h00, 2'h0);
      `CHK("ctrl after reset", 32'h1, rdat)
      `CHK("lamp after reset", 2'h1, modl)
   endtask
   initial begin
      repeat (2) @(posedge clk);
      `CHK("lamps in reset", 6'h00, {modl, chl})
      rst <= 0;
      t_bus();
      t_modes();
      t_persist();
      t_blink();
      t_disable();
      end_of_test();
   end
endmodule // tb_nsl_top
